// *** hdl/lps_pkg.sv ***
package lps_pkg;

  // Timing, all derived from the 100 MHz system clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int RST_LOW_NS = 150;
  localparam int RST_LOW_CYC = (RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_MS = 300;
  localparam int SETTLE_CYC = SETTLE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int LOCK_MS = 160;
  localparam int LOCK_CYC = LOCK_MS * 1000000 / CLK_PERIOD_NS;

  // Host register offsets on APB
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SETUP = 8'h04;
  localparam logic [7:0] A_SETTLE = 8'h08;
  localparam logic [7:0] A_LOCK = 8'h0C;
  localparam logic [7:0] A_STATUS = 8'h10;

  // Setup register fields
  localparam int F_RATE_LSB = 0;
  localparam int F_MODE_LSB = 4;
  localparam int F_VOL_LSB = 8;
  localparam int F_FILT_LSB = 16;
  localparam logic [31:0] SETUP_RESET = 32'h0000_0000;

  // Status register fields
  localparam int S_BUSY = 0;
  localparam int S_LINE = 1;
  localparam int S_MSTOP = 2;
  localparam int S_SSTOP = 3;
  localparam int S_PDN = 4;
  localparam int S_REFUSED = 5;
  localparam int S_VCM = 6;
  localparam int S_STATE_LSB = 8;

  // Codec register addresses and bit masks
  localparam logic [7:0] DEV_PM1 = 8'h00;
  localparam logic [7:0] DEV_PM2 = 8'h01;
  localparam logic [7:0] DEV_PATH = 8'h02;
  localparam logic [7:0] DEV_MODE = 8'h05;
  localparam logic [7:0] DEV_VOL3 = 8'h0F;
  localparam logic [7:0] DEV_FILT = 8'h26;
  localparam logic [7:0] M_VCM = 8'h40;
  localparam logic [7:0] M_DAC = 8'h04;
  localparam logic [7:0] M_BP = 8'h20;
  localparam logic [7:0] M_LO = 8'h02;
  localparam logic [7:0] M_PLL = 8'h01;
  localparam logic [7:0] M_MASTER_CLOCK_OUT_ENABLE = 8'h02;
  localparam logic [7:0] M_DAC_TO_LINEOUT_PATH = 8'h10;
  localparam logic [7:0] M_LINEOUT_POWER_SAVE = 8'h40;
  localparam logic [7:0] DEV_RESET = 8'h00;

  typedef enum logic [2:0] {
    CMD_NONE = 3'b000, CMD_INIT = 3'b001, CMD_UP = 3'b010,
    CMD_DOWN = 3'b011, CMD_CLKSTOP = 3'b100, CMD_OFF = 3'b101
  } lps_cmd_t;

  typedef enum logic [1:0] {
    CM_EXT_SLAVE = 2'b00, CM_PLL_MASTER = 2'b01,
    CM_PLL_SLAVE_FS = 2'b10, CM_PLL_SLAVE_MCK = 2'b11
  } lps_clkmode_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00000, S_RST_LOW = 5'b00001, S_VCM_ON = 5'b00010,
    S_PLL_ON = 5'b00011, S_RATE = 5'b00100, S_LOCK = 5'b00101,
    S_PATH_ON = 5'b00110, S_VOL = 5'b00111, S_FILT = 5'b01000,
    S_LINEOUT_POWER_SAVE_ON = 5'b01001, S_PWR_ON = 5'b01010, S_RISE = 5'b01011,
    S_LINEOUT_POWER_SAVE_OFF = 5'b01100, S_DN_LINEOUT_POWER_SAVE = 5'b01101, S_PWR_OFF = 5'b01110,
    S_FALL = 5'b01111, S_PATH_OFF = 5'b10000, S_DN_LINEOUT_POWER_SAVE_OFF = 5'b10001,
    S_PLL_OFF = 5'b10010, S_MASTER_CLOCK_OUT_ENABLE_OFF = 5'b10011, S_CLK_STOP = 5'b10100,
    S_VCM_OFF = 5'b10101
  } lps_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } lps_devwr_t;

endpackage

// *** hdl/lps_host_seq.sv ***
`timescale 1ns/1ps

module lps_host_seq #(
  parameter logic [31:0] SETTLE_CYCLES = 32'(lps_pkg::SETTLE_CYC),
  parameter logic [31:0] LOCK_CYCLES = 32'(lps_pkg::LOCK_CYC)
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output lps_pkg::lps_devwr_t devWr,
  output logic devWrValid,
  input wire logic devWrReady,
  output logic powerDownPin_b,
  output logic masterClkStop,
  output logic serialClkStop
);

  lps_pkg::lps_state_t state_q, nxt, cmdStart;
  lps_pkg::lps_devwr_t devWr_q, wrReq;
  logic devWrValid_q, isWr, accept, waitDone, cmdOk, cmdWr, cmdTake, pllMode;
  logic [31:0] prdata_q, setup_q, settleCyc_q, lockCyc_q, waitCnt_q, waitLimit, rdMux;
  logic pready_q, pslverr_q, pdn_q, mStop_q, sStop_q, lineOn_q, offPend_q, refused_q;
  logic [7:0] pm1_q, pm2_q, path_q, vol, filt;
  logic [3:0] rate;
  lps_pkg::lps_clkmode_t mode;
  lps_pkg::lps_cmd_t cmd;
  logic mapped;

  assign rate = setup_q[lps_pkg::F_RATE_LSB +: 4];
  assign mode = lps_pkg::lps_clkmode_t'(setup_q[lps_pkg::F_MODE_LSB +: 2]);
  assign vol = setup_q[lps_pkg::F_VOL_LSB +: 8];
  assign filt = setup_q[lps_pkg::F_FILT_LSB +: 8];
  assign pllMode = (mode != lps_pkg::CM_EXT_SLAVE);
  assign accept = devWrValid_q && devWrReady;
  assign cmd = lps_pkg::lps_cmd_t'(pwdata[2:0]);
  assign cmdWr = psel && penable && pready_q && pwrite && (paddr == lps_pkg::A_CTRL);
  assign cmdTake = cmdWr && (state_q == lps_pkg::S_IDLE) && cmdOk;

  // Command legality; refused orders leave the codec untouched
  always_comb begin
    cmdOk = 1'b0;
    cmdStart = lps_pkg::S_IDLE;
    unique case (cmd)
      lps_pkg::CMD_INIT: begin
        cmdOk = 1'b1;
        cmdStart = lps_pkg::S_RST_LOW;
      end
      lps_pkg::CMD_UP: begin
        cmdOk = !lineOn_q && pdn_q && (pm1_q & lps_pkg::M_VCM) != 8'h00 && !mStop_q && !sStop_q;
        cmdStart = lps_pkg::S_RATE;
      end
      lps_pkg::CMD_DOWN: begin
        cmdOk = lineOn_q;
        cmdStart = lps_pkg::S_DN_LINEOUT_POWER_SAVE;
      end
      // clocks stop only with line path idle
      lps_pkg::CMD_CLKSTOP: begin
        cmdOk = !lineOn_q && pdn_q && !mStop_q && !sStop_q;
        cmdStart = pllMode ? lps_pkg::S_PLL_OFF : lps_pkg::S_CLK_STOP;
      end
      // off only with line path idle; unless a clock is already stopped, the clock stop steps run before COMMON_VOLTAGE
      lps_pkg::CMD_OFF: begin
        cmdOk = !lineOn_q && pdn_q;
        if (mStop_q || sStop_q) begin
          cmdStart = lps_pkg::S_VCM_OFF;
        end else begin
          cmdStart = pllMode ? lps_pkg::S_PLL_OFF : lps_pkg::S_CLK_STOP;
        end
      end
      default: begin
        cmdOk = 1'b0;
        cmdStart = lps_pkg::S_IDLE;
      end
    endcase
  end

  // Step table: codec write of each state and the state after it
  always_comb begin
    isWr = 1'b1;
    wrReq = '{addr: lps_pkg::DEV_PM1, data: pm1_q};
    nxt = lps_pkg::S_IDLE;
    unique case (state_q)
      lps_pkg::S_IDLE: isWr = 1'b0;
      lps_pkg::S_RST_LOW: begin
        isWr = 1'b0;
        nxt = lps_pkg::S_VCM_ON;
      end
      lps_pkg::S_VCM_ON: begin
        wrReq.data = pm1_q | lps_pkg::M_VCM;
        nxt = pllMode ? lps_pkg::S_PLL_ON : lps_pkg::S_IDLE;
      end
      lps_pkg::S_PLL_ON: begin
        wrReq.addr = lps_pkg::DEV_PM2;
        wrReq.data = pm2_q | lps_pkg::M_PLL;
        if (mode == lps_pkg::CM_PLL_MASTER || mode == lps_pkg::CM_PLL_SLAVE_MCK) begin
          wrReq.data = pm2_q | lps_pkg::M_PLL | lps_pkg::M_MASTER_CLOCK_OUT_ENABLE;
        end
      end
      lps_pkg::S_RATE: begin
        wrReq = '{addr: lps_pkg::DEV_MODE, data: {4'h0, rate}};
        nxt = pllMode ? lps_pkg::S_LOCK : lps_pkg::S_PATH_ON;
      end
      lps_pkg::S_LOCK: begin
        isWr = 1'b0;
        nxt = lps_pkg::S_PATH_ON;
      end
      lps_pkg::S_PATH_ON: begin
        wrReq = '{addr: lps_pkg::DEV_PATH, data: path_q | lps_pkg::M_DAC_TO_LINEOUT_PATH};
        nxt = lps_pkg::S_VOL;
      end
      lps_pkg::S_VOL: begin
        wrReq = '{addr: lps_pkg::DEV_VOL3, data: vol};
        nxt = lps_pkg::S_FILT;
      end
      lps_pkg::S_FILT: begin
        wrReq = '{addr: lps_pkg::DEV_FILT, data: filt};
        nxt = lps_pkg::S_LINEOUT_POWER_SAVE_ON;
      end
      lps_pkg::S_LINEOUT_POWER_SAVE_ON: begin
        wrReq = '{addr: lps_pkg::DEV_PATH, data: path_q | lps_pkg::M_LINEOUT_POWER_SAVE};
        nxt = lps_pkg::S_PWR_ON;
      end
      lps_pkg::S_PWR_ON: begin
        wrReq.data = pm1_q | lps_pkg::M_DAC | lps_pkg::M_BP | lps_pkg::M_LO;
        nxt = lps_pkg::S_RISE;
      end
      lps_pkg::S_RISE: begin
        isWr = 1'b0;
        nxt = lps_pkg::S_LINEOUT_POWER_SAVE_OFF;
      end
      lps_pkg::S_LINEOUT_POWER_SAVE_OFF: begin
        wrReq = '{addr: lps_pkg::DEV_PATH, data: path_q & ~lps_pkg::M_LINEOUT_POWER_SAVE};
      end
      lps_pkg::S_DN_LINEOUT_POWER_SAVE: begin
        wrReq = '{addr: lps_pkg::DEV_PATH, data: path_q | lps_pkg::M_LINEOUT_POWER_SAVE};
        nxt = lps_pkg::S_PWR_OFF;
      end
      lps_pkg::S_PWR_OFF: begin
        wrReq.data = pm1_q & ~(lps_pkg::M_DAC | lps_pkg::M_BP | lps_pkg::M_LO);
        nxt = lps_pkg::S_FALL;
      end
      lps_pkg::S_FALL: begin
        isWr = 1'b0;
        nxt = lps_pkg::S_PATH_OFF;
      end
      lps_pkg::S_PATH_OFF: begin
        wrReq = '{addr: lps_pkg::DEV_PATH, data: path_q & ~lps_pkg::M_DAC_TO_LINEOUT_PATH};
        nxt = lps_pkg::S_DN_LINEOUT_POWER_SAVE_OFF;
      end
      lps_pkg::S_DN_LINEOUT_POWER_SAVE_OFF: begin
        wrReq = '{addr: lps_pkg::DEV_PATH, data: path_q & ~lps_pkg::M_LINEOUT_POWER_SAVE};
      end
      lps_pkg::S_PLL_OFF: begin
        wrReq = '{addr: lps_pkg::DEV_PM2, data: pm2_q & ~lps_pkg::M_PLL};
        nxt = (mode == lps_pkg::CM_PLL_SLAVE_FS) ? lps_pkg::S_CLK_STOP : lps_pkg::S_MASTER_CLOCK_OUT_ENABLE_OFF;
      end
      lps_pkg::S_MASTER_CLOCK_OUT_ENABLE_OFF: begin
        wrReq = '{addr: lps_pkg::DEV_PM2, data: pm2_q & ~lps_pkg::M_MASTER_CLOCK_OUT_ENABLE};
        nxt = lps_pkg::S_CLK_STOP;
      end
      lps_pkg::S_CLK_STOP: begin
        isWr = 1'b0;
        nxt = offPend_q ? lps_pkg::S_VCM_OFF : lps_pkg::S_IDLE;
      end
      lps_pkg::S_VCM_OFF: wrReq.data = pm1_q & ~lps_pkg::M_VCM;
      default: isWr = 1'b0;
    endcase
  end

  // wait length per waiting state; zero acts as one cycle
  always_comb begin
    unique case (state_q)
      // Pin only falls one cycle after entry, so one more cycle keeps it low long enough
      lps_pkg::S_RST_LOW: waitLimit = 32'(lps_pkg::RST_LOW_CYC) + 32'h0000_0001;
      lps_pkg::S_LOCK: waitLimit = lockCyc_q;
      lps_pkg::S_RISE, lps_pkg::S_FALL: waitLimit = settleCyc_q;
      default: waitLimit = 32'h0000_0001;
    endcase
  end
  assign waitDone = ({1'b0, waitCnt_q} + 33'h0_0000_0001) >= {1'b0, waitLimit};

  // cycle counter, restarts in every state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      waitCnt_q <= 32'h0000_0000;
    end else if (state_q == lps_pkg::S_IDLE || isWr || waitDone) begin
      waitCnt_q <= 32'h0000_0000;
    end else begin
      waitCnt_q <= waitCnt_q + 32'h0000_0001;
    end
  end

  // Sequencer and codec write handshake; request held until taken
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= lps_pkg::S_IDLE;
      devWrValid_q <= 1'b0;
      devWr_q <= '0;
    end else if (state_q == lps_pkg::S_IDLE) begin
      if (cmdTake) begin
        state_q <= cmdStart;
      end
    end else if (!isWr) begin
      // advance only when the count expires
      if (waitDone) begin
        state_q <= nxt;
      end
    end else if (!devWrValid_q) begin
      devWrValid_q <= 1'b1;
      devWr_q <= wrReq;
    end else if (devWrReady) begin
      devWrValid_q <= 1'b0;
      state_q <= nxt;
    end
  end

  // Shadow of codec registers; the pin reset returns them to default
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pm1_q <= lps_pkg::DEV_RESET;
      pm2_q <= lps_pkg::DEV_RESET;
      path_q <= lps_pkg::DEV_RESET;
    end else if (state_q == lps_pkg::S_RST_LOW) begin
      pm1_q <= lps_pkg::DEV_RESET;
      pm2_q <= lps_pkg::DEV_RESET;
      path_q <= lps_pkg::DEV_RESET;
    end else if (accept) begin
      if (devWr_q.addr == lps_pkg::DEV_PM1) begin
        pm1_q <= devWr_q.data;
      end
      if (devWr_q.addr == lps_pkg::DEV_PM2) begin
        pm2_q <= devWr_q.data;
      end
      if (devWr_q.addr == lps_pkg::DEV_PATH) begin
        path_q <= devWr_q.data;
      end
    end
  end

  // Pin and clock-stop levels; pin stays low from reset until an init order
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pdn_q <= 1'b0;
      mStop_q <= 1'b0;
      sStop_q <= 1'b0;
    end else if (state_q == lps_pkg::S_RST_LOW) begin
      // falls after the first cycle of the reset state, rises as the state ends
      pdn_q <= waitDone;
      mStop_q <= 1'b0;
      sStop_q <= 1'b0;
    end else if (state_q == lps_pkg::S_CLK_STOP) begin
      mStop_q <= (mode != lps_pkg::CM_PLL_SLAVE_FS);
      sStop_q <= (mode == lps_pkg::CM_PLL_SLAVE_FS) || (mode == lps_pkg::CM_EXT_SLAVE);
    end
  end

  // Line status, pending shutdown and refusal flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lineOn_q <= 1'b0;
      offPend_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      if (accept && state_q == lps_pkg::S_LINEOUT_POWER_SAVE_OFF) begin
        lineOn_q <= 1'b1;
      end else if (accept && state_q == lps_pkg::S_DN_LINEOUT_POWER_SAVE) begin
        lineOn_q <= 1'b0;
      end
      if (cmdTake) begin
        offPend_q <= (cmd == lps_pkg::CMD_OFF);
        refused_q <= 1'b0;
      end else if (cmdWr) begin
        refused_q <= 1'b1;
      end
    end
  end

  // APB read mux; unmapped offsets answer with an error
  assign mapped = (paddr == lps_pkg::A_CTRL) || (paddr == lps_pkg::A_SETUP)
               || (paddr == lps_pkg::A_SETTLE) || (paddr == lps_pkg::A_LOCK)
               || (paddr == lps_pkg::A_STATUS);
  always_comb begin
    rdMux = 32'h0000_0000;
    if (paddr == lps_pkg::A_SETUP) begin
      rdMux = setup_q;
    end else if (paddr == lps_pkg::A_SETTLE) begin
      rdMux = settleCyc_q;
    end else if (paddr == lps_pkg::A_LOCK) begin
      rdMux = lockCyc_q;
    end else if (paddr == lps_pkg::A_STATUS) begin
      rdMux[lps_pkg::S_BUSY] = (state_q != lps_pkg::S_IDLE);
      rdMux[lps_pkg::S_LINE] = lineOn_q;
      rdMux[lps_pkg::S_MSTOP] = mStop_q;
      rdMux[lps_pkg::S_SSTOP] = sStop_q;
      rdMux[lps_pkg::S_PDN] = pdn_q;
      rdMux[lps_pkg::S_REFUSED] = refused_q;
      rdMux[lps_pkg::S_VCM] = (pm1_q & lps_pkg::M_VCM) != 8'h00;
      rdMux[lps_pkg::S_STATE_LSB +: 5] = state_q;
    end
  end

  // APB slave: answer in the first access cycle; settings change only when idle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      setup_q <= lps_pkg::SETUP_RESET;
      settleCyc_q <= SETTLE_CYCLES;
      lockCyc_q <= LOCK_CYCLES;
    end else begin
      pready_q <= psel && !penable;
      pslverr_q <= psel && !penable && !mapped;
      if (psel && !penable) begin
        prdata_q <= rdMux;
      end
      if (psel && penable && pready_q && pwrite && state_q == lps_pkg::S_IDLE) begin
        if (paddr == lps_pkg::A_SETUP) begin
          setup_q <= pwdata & 32'h00FF_FF3F;
        end
        if (paddr == lps_pkg::A_SETTLE) begin
          settleCyc_q <= pwdata;
        end
        if (paddr == lps_pkg::A_LOCK) begin
          lockCyc_q <= pwdata;
        end
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign devWr = devWr_q;
  assign devWrValid = devWrValid_q;
  assign powerDownPin_b = pdn_q;
  assign masterClkStop = mStop_q;
  assign serialClkStop = sStop_q;

  // Helper: consecutive low cycles of the power-down pin, saturating
  logic [7:0] lowCnt_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lowCnt_q <= 8'h00;
    end else if (pdn_q) begin
      lowCnt_q <= 8'h00;
    end else if (lowCnt_q != 8'hFF) begin
      lowCnt_q <= lowCnt_q + 8'h01;
    end
  end

  AST_RST_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(pdn_q) |-> lowCnt_q >= 8'(lps_pkg::RST_LOW_CYC))
    else $error("power-down pin released too early");
  AST_PATH_BEFORE_PWR: assert property (@(posedge clk) disable iff (!rst_b)
    (accept && state_q == lps_pkg::S_PWR_ON) |-> (path_q & lps_pkg::M_DAC_TO_LINEOUT_PATH) != 8'h00)
    else $error("blocks powered before path enable");
  AST_LINEOUT_POWER_SAVE_BEFORE_PWR: assert property (@(posedge clk) disable iff (!rst_b)
    (accept && state_q == lps_pkg::S_PWR_ON) |-> (path_q & lps_pkg::M_LINEOUT_POWER_SAVE) != 8'h00)
    else $error("blocks powered without power-save");
  AST_PWR_TOGETHER: assert property (@(posedge clk) disable iff (!rst_b)
    (accept && state_q == lps_pkg::S_PWR_ON) |=> state_q == lps_pkg::S_RISE
      && (pm1_q & (lps_pkg::M_DAC | lps_pkg::M_BP | lps_pkg::M_LO)) == 8'h26)
    else $error("power bits not set together");
  AST_SETTLE_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    ((state_q == lps_pkg::S_RISE || state_q == lps_pkg::S_FALL)
      && {1'b0, waitCnt_q} + 33'h0_0000_0001 < {1'b0, settleCyc_q})
      |=> $stable(state_q) && !devWrValid_q)
    else $error("settle wait cut short");
  AST_LINEOUT_POWER_SAVE_AFTER_RISE: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(state_q == lps_pkg::S_LINEOUT_POWER_SAVE_OFF) |-> $past(state_q) == lps_pkg::S_RISE)
    else $error("power-save cleared before outputs rose");
  AST_DOWN_ORDER: assert property (@(posedge clk) disable iff (!rst_b)
    (accept && state_q == lps_pkg::S_PWR_OFF) |-> (path_q & lps_pkg::M_LINEOUT_POWER_SAVE) != 8'h00)
    else $error("power bits cleared without power-save");
  AST_PATH_OFF_LATE: assert property (@(posedge clk) disable iff (!rst_b)
    (accept && state_q == lps_pkg::S_DN_LINEOUT_POWER_SAVE_OFF) |-> (path_q & lps_pkg::M_DAC_TO_LINEOUT_PATH) == 8'h00
      && (pm1_q & lps_pkg::M_LO) == 8'h00)
    else $error("power-save cleared before path off");
  AST_PLL_BEFORE_STOP: assert property (@(posedge clk) disable iff (!rst_b)
    ($rose(mStop_q) && pllMode) |-> (pm2_q & (lps_pkg::M_PLL | lps_pkg::M_MASTER_CLOCK_OUT_ENABLE)) == 8'h00
      || mode == lps_pkg::CM_PLL_SLAVE_FS)
    else $error("master clock stopped with PLL or clock-out on");
  AST_VCM_LAST: assert property (@(posedge clk) disable iff (!rst_b)
    (accept && state_q == lps_pkg::S_VCM_OFF) |-> (mStop_q || sStop_q) && !lineOn_q)
    else $error("COMMON_VOLTAGE cleared before clocks stopped");

endmodule

// *** bench/lps_codec_model.sv ***
`timescale 1ns/1ps

// Behavioural codec seen through its control port and reset pin
module lps_codec_model (
  input wire logic clk,
  input wire lps_pkg::lps_devwr_t devWr,
  input wire logic devWrValid,
  output logic devWrReady,
  input wire logic powerDownPin_b,
  input wire logic slowMode
);
  logic [7:0] regs [256];
  logic [7:0] logA [$];
  logic [7:0] logD [$];
  int logT [$];
  int cycle = 0;
  logic [1:0] slowCnt = 2'h0;
  logic lineNormal;

  // Accept at once, or one cycle in four to stall the sequencer
  always @(posedge clk) begin
    cycle <= cycle + 1;
    slowCnt <= slowCnt + 2'h1;
    devWrReady <= !slowMode || (slowCnt == 2'h2);
  end

  always @(posedge clk or negedge powerDownPin_b) begin
    if (!powerDownPin_b) begin
      foreach (regs[i]) regs[i] <= 8'h00;
    end else if (devWrValid && devWrReady) begin
      regs[devWr.addr] <= devWr.data;
      logA.push_back(devWr.addr);
      logD.push_back(devWr.data);
      logT.push_back(cycle);
    end
  end

  // amp on, normal once save off
  assign lineNormal = ((regs[lps_pkg::DEV_PM1] & lps_pkg::M_LO) != 8'h00) &&
                      ((regs[lps_pkg::DEV_PATH] & lps_pkg::M_LINEOUT_POWER_SAVE) == 8'h00);
endmodule

// *** bench/tb.sv ***
`timescale 1ns/1ps

module tb;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, slowMode;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, st;
  lps_pkg::lps_devwr_t devWr;
  logic devWrValid, devWrReady, powerDownPin_b, masterClkStop, serialClkStop;
  logic [15:0] expQ [$];
  int failures, samples_checked, lowRun, lastLow, stopT;

  // Short waits so a sequence finishes in tens of cycles
  lps_host_seq #(.SETTLE_CYCLES(32'd20), .LOCK_CYCLES(32'd10)) dut_u (.clk(clk),
    .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .devWr(devWr),
    .devWrValid(devWrValid), .devWrReady(devWrReady), .powerDownPin_b(powerDownPin_b),
    .masterClkStop(masterClkStop), .serialClkStop(serialClkStop));
  lps_codec_model codec_u (.clk(clk), .devWr(devWr), .devWrValid(devWrValid),
    .devWrReady(devWrReady), .powerDownPin_b(powerDownPin_b), .slowMode(slowMode));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Last low phase of the reset pin, last cycle with both clocks running
  always @(posedge clk) begin
    lowRun <= powerDownPin_b ? 0 : lowRun + 1;
    if (powerDownPin_b && lowRun != 0) lastLow <= lowRun;
    if (!(masterClkStop || serialClkStop)) stopT <= codec_u.cycle;
  end

  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Codec writes seen against the expected list, then both cleared
  task automatic chkLog();
    chkVal(32'(codec_u.logA.size()), 32'(expQ.size()), "write count");
    foreach (expQ[i])
      if (i < codec_u.logA.size())
        chkVal({16'h0000, codec_u.logA[i], codec_u.logD[i]}, {16'h0000, expQ[i]}, "write");
    expQ.delete();
    codec_u.logA.delete();
    codec_u.logD.delete();
    codec_u.logT.delete();
  endtask

  task automatic want(input logic [7:0] a, input logic [7:0] d);
    expQ.push_back({a, d});
  endtask

  function automatic logic [31:0] gap(input int i);
    return 32'(codec_u.logT[i + 1] - codec_u.logT[i]);
  endfunction

  // One APB transfer; the request holds until pready is sampled high
  task automatic apbXfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n >= 50) begin
      failures++;
      $display("unexpected at %0t: no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic apbWr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apbXfer(1'b1, a, d, r, e);
  endtask

  task automatic rdSt();
    logic e;
    apbXfer(1'b0, lps_pkg::A_STATUS, 32'h0000_0000, st, e);
  endtask

  // Issue a command and poll busy; a refused one is never busy
  task automatic runCmd(input lps_pkg::lps_cmd_t c);
    int n;
    n = 0;
    apbWr(lps_pkg::A_CTRL, {29'h0000_0000, c});
    rdSt();
    while (st[lps_pkg::S_BUSY] !== 1'b0 && n < 500) begin
      n++;
      rdSt();
    end
    if (n >= 500) begin
      failures++;
      $display("unexpected at %0t: command never finished", $time);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog well beyond the length of all sequences
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    $display("unexpected at %0t: run timed out", $time);
    stop_test();
  end

  // Main sequence of tests
  initial begin
    logic [31:0] d;
    logic e;
    failures = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    slowMode = 1'b0;
    lowRun = 0;
    lastLow = 0;
    stopT = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdSt();
    chkVal(st, 32'h0000_0000, "status reset");
    apbXfer(1'b0, lps_pkg::A_SETUP, 32'h0000_0000, d, e);
    chkVal(d, lps_pkg::SETUP_RESET, "setup reset");
    apbXfer(1'b0, 8'h20, 32'h0000_0000, d, e);
    chkVal({e, d[30:0]}, 32'h8000_0000, "unmapped read");
    apbWr(lps_pkg::A_SETTLE, 32'd20);
    apbWr(lps_pkg::A_LOCK, 32'd10);
    apbXfer(1'b0, lps_pkg::A_SETTLE, 32'h0000_0000, d, e);
    chkVal(d, 32'd20, "settle reg");
    runCmd(lps_pkg::CMD_UP);
    chkVal(32'(st[lps_pkg::S_REFUSED]), 32'd1, "up without common_voltage");
    chkLog();
    $display("test registers done");
    apbWr(lps_pkg::A_SETUP, 32'h003C_A515);
    runCmd(lps_pkg::CMD_INIT);
    want(lps_pkg::DEV_PM1, lps_pkg::M_VCM);
    want(lps_pkg::DEV_PM2, lps_pkg::M_PLL | lps_pkg::M_MASTER_CLOCK_OUT_ENABLE);
    chkLog();
    slowMode <= 1'b1;
    runCmd(lps_pkg::CMD_UP);
    want(lps_pkg::DEV_MODE, 8'h05);
    want(lps_pkg::DEV_PATH, lps_pkg::M_DAC_TO_LINEOUT_PATH);
    want(lps_pkg::DEV_VOL3, 8'hA5);
    want(lps_pkg::DEV_FILT, 8'h3C);
    want(lps_pkg::DEV_PATH, lps_pkg::M_DAC_TO_LINEOUT_PATH | lps_pkg::M_LINEOUT_POWER_SAVE);
    want(lps_pkg::DEV_PM1, lps_pkg::M_VCM | lps_pkg::M_DAC | lps_pkg::M_BP | lps_pkg::M_LO);
    want(lps_pkg::DEV_PATH, lps_pkg::M_DAC_TO_LINEOUT_PATH);
    if (codec_u.logT.size() == 7) begin
      chkVal(32'(gap(0) >= 32'd10), 32'd1, "lock wait");
      chkVal(32'(gap(5) >= 32'd20), 32'd1, "rise wait");
    end
    chkLog();
    chkVal(32'(codec_u.lineNormal), 32'd1, "line normal");
    chkVal(32'(st[lps_pkg::S_LINE]), 32'd1, "line status");
    runCmd(lps_pkg::CMD_CLKSTOP);
    chkVal(32'(st[lps_pkg::S_REFUSED]), 32'd1, "stop while playing");
    chkVal(32'(masterClkStop), 32'd0, "clock kept");
    runCmd(lps_pkg::CMD_DOWN);
    want(lps_pkg::DEV_PATH, lps_pkg::M_DAC_TO_LINEOUT_PATH | lps_pkg::M_LINEOUT_POWER_SAVE);
    want(lps_pkg::DEV_PM1, lps_pkg::M_VCM);
    want(lps_pkg::DEV_PATH, lps_pkg::M_LINEOUT_POWER_SAVE);
    want(lps_pkg::DEV_PATH, 8'h00);
    if (codec_u.logT.size() == 4)
      chkVal(32'(gap(1) >= 32'd20), 32'd1, "fall wait");
    chkLog();
    chkVal(32'(codec_u.lineNormal), 32'd0, "line off");
    slowMode <= 1'b0;
    $display("test line up and down done");
    // Every clock mode: reset, bring-up and the clock stopping order
    for (int m = 0; m < 4; m++) begin
      apbWr(lps_pkg::A_SETUP, {26'h000_0000, m[1:0], 4'h5});
      runCmd(lps_pkg::CMD_INIT);
      chkVal(32'(lastLow >= lps_pkg::RST_LOW_CYC), 32'd1, "pin low time");
      chkVal({24'h00_0000, codec_u.regs[lps_pkg::DEV_VOL3]}, 32'h0000_0000, "vol default");
      want(lps_pkg::DEV_PM1, lps_pkg::M_VCM);
      if (m != 0)
        want(lps_pkg::DEV_PM2, m[0] ? (lps_pkg::M_PLL | lps_pkg::M_MASTER_CLOCK_OUT_ENABLE) : lps_pkg::M_PLL);
      chkLog();
      runCmd(lps_pkg::CMD_CLKSTOP);
      if (m != 0) want(lps_pkg::DEV_PM2, m[0] ? lps_pkg::M_MASTER_CLOCK_OUT_ENABLE : 8'h00);
      if (m[0]) want(lps_pkg::DEV_PM2, 8'h00);
      if (m != 0 && codec_u.logT.size() != 0)
        chkVal(32'(stopT >= codec_u.logT[$]), 32'd1, "stop after writes");
      chkLog();
      chkVal(32'(masterClkStop), 32'(m != 2), "master stop");
      chkVal(32'(serialClkStop), 32'(m == 0 || m == 2), "serial stop");
    end
    runCmd(lps_pkg::CMD_OFF);
    want(lps_pkg::DEV_PM1, 8'h00);
    chkLog();
    chkVal(32'(st[lps_pkg::S_VCM]), 32'd0, "common_voltage off");
    $display("test clock modes and shutdown done");
    stop_test();
  end
endmodule
